/* rtl/scpm_pkg.sv */
// package for the system clock and power mode controller
package scpm_pkg;

    // register addresses on the plain register port
    localparam logic [7:0] SCPM_ADDR_CLK_MODE = 8'h00;   // clock_mode_control
    localparam logic [7:0] SCPM_ADDR_CTRL     = 8'h01;   // idle keep and watchdog request
    localparam logic [7:0] SCPM_ADDR_STATUS   = 8'h02;   // current operating mode, one-hot

    // clock_mode_control field positions
    localparam int SCPM_POS_DIV_LSB  = 5;                // clock_divide_field is bits 7..5
    localparam int SCPM_POS_LOW_RDY  = 3;                // low_osc_ready_flag
    localparam int SCPM_POS_HIGH_RDY = 2;                // high_osc_ready_flag
    localparam int SCPM_POS_IDLE_SEL = 1;                // halt_idle_select
    localparam int SCPM_POS_HL_SEL   = 0;                // high_low_select

    // second control register field positions
    localparam int SCPM_POS_KEEP     = 0;                // idle_clock_keep
    localparam int SCPM_POS_WDT_REQ  = 1;                // software watchdog enable

    // values after reset
    localparam logic [2:0] SCPM_RST_DIV      = 3'h0;
    localparam logic       SCPM_RST_IDLE_SEL = 1'b1;
    localparam logic       SCPM_RST_HL_SEL   = 1'b1;
    localparam logic [7:0] SCPM_RST_CTRL     = 8'h00;

    // divide codes at or below this value select the sub clock while high_low_select is low
    localparam logic [2:0] SCPM_DIV_SUB_MAX  = 3'h1;
    // shift base: divide code 7 gives ratio 2, code 2 gives ratio 64
    localparam logic [3:0] SCPM_SHIFT_BASE   = 4'h8;

    // writable fields of clock_mode_control
    typedef struct packed {
        logic [2:0] clock_divide_field;
        logic       halt_idle_select;
        logic       high_low_select;
    } scpm_clk_mode_type;

    // operating modes, one-hot
    typedef enum logic [4:0] {
        SCPM_NORMAL   = 5'b00001,
        SCPM_SLOW     = 5'b00010,
        SCPM_SLEEP    = 5'b00100,
        SCPM_IDLE_OFF = 5'b01000,
        SCPM_IDLE_ON  = 5'b10000
    } scpm_mode_type;

endpackage

/* rtl/scpm_divider.sv */
// divider that turns fast oscillator ticks into the divided high-speed tick
`timescale 1ns/1ps
module scpm_divider
    import scpm_pkg::*;
#(
    parameter int CNT_W = 6                      // log2 of the largest ratio
)
(
    // clock and control
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             ce,
    // divider control
    input  wire logic             run,           // low while the fast oscillator is stopped
    input  wire logic [2:0]       shift,         // ratio is two to this power
    input  wire logic             high_tick,     // one tick per fast oscillator period
    // result
    output logic                  div_tick
);

    // a ratio above two to the seventh needs a shift wider than three bits
    initial
    begin
        if (CNT_W < 1 || CNT_W > 7)
            $error("scpm_divider: CNT_W out of range");
    end

    logic [CNT_W-1:0] count;                     // fast ticks seen so far
    wire  [CNT_W-1:0] mask;                      // low bits that must be all ones

    assign mask     = CNT_W'((1 << shift) - 1);
    assign div_tick = run && high_tick && ((count & mask) == mask);

    // counter restarts while stopped so the first divided tick is a full period
    always_ff @(posedge ref_clk)
    begin
        if (srst || (ce && !run))
            count <= '0;
        else if (ce && high_tick)
            count <= CNT_W'(count + 1'b1);
    end

endmodule

/* rtl/scpm_top.sv */
// system clock selection and operating mode controller
//
// Notes on behaviour
// - system clock from high or sub clock
// - high-speed source is fast internal oscillator
// - sub source fixed by build option
// - divided high clock from two to sixty-four
// - switching to sub stops fast oscillator
// - exactly five operating modes
// - normal mode runs divided fast clock
// - slow mode uses sub, high off
// - halt with idle select low sleeps
// - sleep forces watchdog off
// - halt, idle high, keep low: clock-off idle
// - halt, idle and keep high: clock-on idle
// - clock-on idle keeps peripherals clocked
// - ready flags and control register reset to zero; clock_mode_control resets to 03
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module scpm_top
    import scpm_pkg::*;
#(
    parameter bit SUB_FROM_CRYSTAL = 1'b0,       // build option: sub clock from crystal
    parameter int DIV_W            = 6           // divider width, ratio up to 64
)
(
    // clock, reset and enable
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       ce,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // cpu side
    input  wire logic       halt_req,            // one-cycle pulse on a halt instruction
    input  wire logic       wake_req,            // one-cycle pulse from any wake source
    // oscillator ticks and stability
    input  wire logic       fast_osc_tick,
    input  wire logic       slow_internal_tick,
    input  wire logic       slow_crystal_tick,
    input  wire logic       fast_osc_stable,
    input  wire logic       slow_osc_stable,
    // oscillator and clock controls
    output logic            fast_osc_enable,
    output logic            slow_internal_enable,
    output logic            slow_crystal_enable,
    output logic            high_clock_avail,    // divided high clocks usable by peripherals
    output logic            cpu_tick,            // system tick gated to the cpu
    output logic            periph_tick,         // system tick to peripherals
    output logic            sub_tick,            // sub clock tick to timers
    output logic            watchdog_enable,
    output scpm_mode_type   mode
);

    initial
    begin
        if (DIV_W != 6)
            $error("scpm_top: only a six-bit divider is supported");
    end

    // registers
    scpm_clk_mode_type clk_mode;                 // writable part of clock_mode_control
    logic              low_osc_ready_flag;       // sub oscillator stable
    logic              high_osc_ready_flag;      // fast oscillator stable
    logic [7:0]        ctrl;                     // idle keep and watchdog request
    scpm_mode_type     next_mode;

    // address decode
    wire sel_mode   = (reg_addr == SCPM_ADDR_CLK_MODE);
    wire sel_ctrl   = (reg_addr == SCPM_ADDR_CTRL);
    wire sel_status = (reg_addr == SCPM_ADDR_STATUS);
    wire wr_mode    = ce && reg_wr && sel_mode;
    wire wr_ctrl    = ce && reg_wr && sel_ctrl;

    // field views
    wire idle_clock_keep = ctrl[SCPM_POS_KEEP];
    wire wdt_request     = ctrl[SCPM_POS_WDT_REQ];
    wire high_low_select = clk_mode.high_low_select;
    wire [2:0] clock_divide_field = clk_mode.clock_divide_field;
    // the sub oscillator runs in every mode but sleep; the ready flag needs it early
    wire sub_enable = (mode != SCPM_SLEEP);

    // full read image of clock_mode_control, bit 4 reads zero
    wire [7:0] mode_image = {clock_divide_field, 1'b0, low_osc_ready_flag,
                             high_osc_ready_flag, clk_mode.halt_idle_select,
                             high_low_select};

    // status is a read-only window on the mode register for software
    // read data multiplexer; unmapped addresses read zero
    wire [7:0] read_mux = sel_mode   ? mode_image :
                          sel_ctrl   ? ctrl :
                          sel_status ? {3'h0, mode} : 8'h00;

    // writes touch only the writable fields; ready flags ignore them
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            clk_mode <= '{SCPM_RST_DIV, SCPM_RST_IDLE_SEL, SCPM_RST_HL_SEL};
            ctrl     <= SCPM_RST_CTRL;
        end
        else
        begin
            if (wr_mode)
                clk_mode <= '{reg_wdata[7:SCPM_POS_DIV_LSB], reg_wdata[SCPM_POS_IDLE_SEL],
                              reg_wdata[SCPM_POS_HL_SEL]};
            if (wr_ctrl)
                ctrl <= {6'h00, reg_wdata[SCPM_POS_WDT_REQ], reg_wdata[SCPM_POS_KEEP]};
        end
    end

    // ready flags follow stability of an enabled oscillator only
    // they lag stability by one cycle; the block never waits for them, so
    // software polls them before it switches to a freshly started oscillator
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            low_osc_ready_flag  <= 1'b0;
            high_osc_ready_flag <= 1'b0;
        end
        else if (ce)
        begin
            low_osc_ready_flag  <= sub_enable && slow_osc_stable;
            high_osc_ready_flag <= fast_osc_enable && fast_osc_stable;
        end
    end

    // read data stand one cycle after the strobe, and only then
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (ce)
            reg_rdata <= reg_rd ? read_mux : 8'h00;
    end

    // clock selection
    // codes 000 and 001 with the low select pick the sub clock
    wire use_sub = !high_low_select && (clock_divide_field <= SCPM_DIV_SUB_MAX);
    // ratio: undivided when high select is set, else two to the shift
    wire [3:0] shift_wide = SCPM_SHIFT_BASE - {1'b0, clock_divide_field};
    wire [2:0] div_shift  = high_low_select ? 3'h0 : shift_wide[2:0];

    // the high-speed clock exists only while the fast oscillator runs
    // going back from sub to high restarts the oscillator; the divided tick then
    // waits for real oscillator ticks, so no short period reaches the cpu
    wire fast_run = (mode == SCPM_NORMAL) ||
                    ((mode == SCPM_IDLE_ON) && !use_sub);
    wire div_tick;

    // divided fast oscillator tick
    scpm_divider #(
        .CNT_W     (DIV_W)
    ) scpm_divider_inst (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .ce        (ce),
        .run       (fast_run),
        .shift     (div_shift),
        .high_tick (fast_osc_tick),              // only the fast internal oscillator
        .div_tick  (div_tick)
    );

    // sub source fixed at build time, never switched by software
    wire sub_src_tick = SUB_FROM_CRYSTAL ? slow_crystal_tick : slow_internal_tick;
    wire sub_live     = sub_enable && sub_src_tick;
    wire sys_tick     = use_sub ? sub_live : div_tick;

    // cpu runs in normal and slow; peripherals also in clock-on idle
    wire cpu_on    = (mode == SCPM_NORMAL) || (mode == SCPM_SLOW);
    wire periph_on = cpu_on || (mode == SCPM_IDLE_ON);

    assign cpu_tick             = ce && cpu_on && sys_tick;
    assign periph_tick          = ce && periph_on && sys_tick;
    assign sub_tick             = ce && sub_live;
    assign fast_osc_enable      = fast_run;
    assign high_clock_avail     = fast_run;
    assign slow_internal_enable = sub_enable && !SUB_FROM_CRYSTAL;
    assign slow_crystal_enable  = sub_enable && SUB_FROM_CRYSTAL;
    // watchdog follows software except in sleep, where hardware forces it off
    // the request bit itself is kept, so the watchdog resumes on wake
    assign watchdog_enable      = wdt_request && (mode != SCPM_SLEEP);

    // mode machine
    // running modes follow the clock selection; halt chooses the low-power mode
    // a halt that meets a register write uses the old fields, so software
    // sets the selection at least one instruction ahead of the halt
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            SCPM_NORMAL, SCPM_SLOW:
            begin
                if (halt_req)
                begin
                    if (!clk_mode.halt_idle_select)
                        next_mode = SCPM_SLEEP;
                    else if (!idle_clock_keep)
                        next_mode = SCPM_IDLE_OFF;
                    else
                        next_mode = SCPM_IDLE_ON;
                end
                else
                    next_mode = use_sub ? SCPM_SLOW : SCPM_NORMAL;
            end
            SCPM_SLEEP, SCPM_IDLE_OFF, SCPM_IDLE_ON:
            begin
                if (wake_req)
                    next_mode = use_sub ? SCPM_SLOW : SCPM_NORMAL;
            end
            default:
                next_mode = SCPM_NORMAL;                               // illegal code recovers
        endcase
    end

    // mode register; reset selection is undivided high clock, hence normal
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mode <= SCPM_NORMAL;
        else if (ce)
            mode <= next_mode;
    end

    // checks on the mode machine and clock gating
    // they watch only what this block drives, and reset disables them
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_mode_one_hot: assert property ($onehot(mode))
        else $error("mode is not one of the five codes");

    a_sleep_entry: assert property (ce && cpu_on && halt_req && !clk_mode.halt_idle_select
        |=> mode == SCPM_SLEEP && !sub_tick && !cpu_tick)
        else $error("halt with idle select low did not sleep");

    a_idle_off_entry: assert property (ce && cpu_on && halt_req && clk_mode.halt_idle_select
        && !idle_clock_keep |=> mode == SCPM_IDLE_OFF && !fast_osc_enable)
        else $error("clock-off idle not entered");

    a_idle_on_entry: assert property (ce && cpu_on && halt_req && clk_mode.halt_idle_select
        && idle_clock_keep |=> mode == SCPM_IDLE_ON)
        else $error("clock-on idle not entered");

    a_sleep_no_wdt: assert property (mode == SCPM_SLEEP |-> !watchdog_enable)
        else $error("watchdog active in sleep");

    a_slow_high_off: assert property (mode == SCPM_SLOW |-> !fast_osc_enable
        && !high_clock_avail)
        else $error("fast oscillator running in slow mode");

    a_idle_on_periph: assert property (mode == SCPM_IDLE_ON && sys_tick && ce
        |-> periph_tick && !cpu_tick)
        else $error("clock-on idle gating wrong");

    a_ready_read_only: assert property (wr_mode && sub_enable |=> $stable(low_osc_ready_flag)
        || $past(slow_osc_stable) != $past(low_osc_ready_flag))
        else $error("ready flag changed by a write");

    a_reset_image: assert property ($past(srst) |-> clk_mode.halt_idle_select
        && high_low_select && clock_divide_field == 3'h0)
        else $error("clock mode reset value wrong");

    a_running_select: assert property (ce && cpu_on && !halt_req && !wr_mode
        |=> mode == (use_sub ? SCPM_SLOW : SCPM_NORMAL))
        else $error("running mode does not follow clock selection");

    a_high_flag_ro: assert property (wr_mode && fast_osc_enable |=>
        $stable(high_osc_ready_flag) || $past(fast_osc_stable) != $past(high_osc_ready_flag))
        else $error("high ready flag changed by a write");

    a_sleep_osc_off: assert property (mode == SCPM_SLEEP |->
        !fast_osc_enable && !slow_internal_enable && !slow_crystal_enable)
        else $error("oscillator enabled in sleep");

    a_normal_fast_on: assert property (mode == SCPM_NORMAL |->
        fast_osc_enable && high_clock_avail)
        else $error("fast oscillator stopped in normal mode");

    a_idle_off_gating: assert property (mode == SCPM_IDLE_OFF |->
        !cpu_tick && !periph_tick && !fast_osc_enable
        && (slow_internal_enable || slow_crystal_enable))
        else $error("clock-off idle gating wrong");

    a_sub_tick_source: assert property (ce && mode != SCPM_SLEEP |->
        sub_tick == (SUB_FROM_CRYSTAL ? slow_crystal_tick : slow_internal_tick))
        else $error("sub clock tick from the wrong source");

    a_ready_reset: assert property ($past(srst) |->
        !low_osc_ready_flag && !high_osc_ready_flag)
        else $error("ready flag set after reset");

    a_idle_on_fast: assert property (mode == SCPM_IDLE_ON && !use_sub |->
        fast_osc_enable && high_clock_avail)
        else $error("fast clock stopped in clock-on idle");

    c_sleep_wake: cover property (mode == SCPM_SLEEP ##1 mode == SCPM_NORMAL);
    c_idle_off: cover property (mode == SCPM_IDLE_OFF && sub_tick);
    c_idle_on: cover property (mode == SCPM_IDLE_ON && periph_tick);
    c_slow_run: cover property (mode == SCPM_SLOW && cpu_tick);
    c_div64: cover property (mode == SCPM_NORMAL && div_shift == 3'h6 && cpu_tick);

endmodule

/* verif/scpm_osc_model.sv */
// oscillator bank model that feeds ticks and stability levels to the controller
`timescale 1ns/1ps
module scpm_osc_model
#(
    parameter int FAST_DIV = 2,                  // ref cycles per fast oscillator tick
    parameter int IRC_DIV  = 16,                 // ref cycles per slow internal tick
    parameter int XTL_DIV  = 20,                 // crystal differs so a wrong pick shows
    parameter int START    = 6                   // cycles from enable to stable
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // enables from the controller
    input  wire logic fast_osc_enable,
    input  wire logic slow_internal_enable,
    input  wire logic slow_crystal_enable,
    // ticks and stability levels
    output logic      fast_osc_tick,
    output logic      slow_internal_tick,
    output logic      slow_crystal_tick,
    output logic      fast_osc_stable,
    output logic      slow_osc_stable
);
    int fc, ic, xc, fs, ss;                      // phase and start-up counters
    logic slow_on;                               // either slow source enabled

    assign slow_on = slow_internal_enable | slow_crystal_enable;
    // a disabled source loses phase and must start up again, no free ticks
    always_ff @(posedge ref_clk)
    begin
        fc <= (srst || !fast_osc_enable) ? 0 : (fc + 1) % FAST_DIV;
        ic <= (srst || !slow_internal_enable) ? 0 : (ic + 1) % IRC_DIV;
        xc <= (srst || !slow_crystal_enable) ? 0 : (xc + 1) % XTL_DIV;
        fs <= (srst || !fast_osc_enable) ? 0 : (fs < START ? fs + 1 : fs);
        ss <= (srst || !slow_on) ? 0 : (ss < START ? ss + 1 : ss);
    end
    // stability only after the start-up delay; ticks only from a stable source
    assign fast_osc_stable    = (fs == START);
    assign slow_osc_stable    = (ss == START);
    assign fast_osc_tick      = fast_osc_stable && (fc == FAST_DIV - 1);
    assign slow_internal_tick = slow_osc_stable && slow_internal_enable && (ic == IRC_DIV - 1);
    assign slow_crystal_tick  = slow_osc_stable && slow_crystal_enable && (xc == XTL_DIV - 1);
endmodule

/* verif/test_scpm_top.sv */
// self-checking bench for the clock and power mode controller
`timescale 1ns/1ps
module test_scpm_top;
    import scpm_pkg::*;
    logic          ref_clk, srst, ce;             // clock, reset, enable
    logic    [7:0] reg_addr, reg_wdata, reg_rdata; // register port
    logic          reg_wr, reg_rd;                // register strobes
    logic          halt_req, wake_req;            // cpu side pulses
    logic          f_tick, i_tick, x_tick;        // oscillator ticks
    logic          f_stable, s_stable;            // oscillator stability
    logic          f_en, i_en, x_en, h_avail;     // oscillator controls
    logic          cpu_tick, periph_tick, sub_tick, wdt_en;
    scpm_mode_type mode;                          // current mode
    int            miscompares, cmp_count, cycles;
    int            n_cpu, n_per, n_sub, g;        // tick counts and gaps
    logic          x_f_tick, x_i_tick, x_x_tick;  // crystal build oscillator ticks
    logic          x_f_stable, x_s_stable;        // crystal build stability
    logic          x_f_en, x_i_en, x_x_en, x_sub_tick; // crystal build controls
    int            n_xbad;                        // crystal build sub tick mismatches

    scpm_top scpm_top_inst (.ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .halt_req(halt_req), .wake_req(wake_req), .fast_osc_tick(f_tick),
        .slow_internal_tick(i_tick), .slow_crystal_tick(x_tick), .fast_osc_stable(f_stable),
        .slow_osc_stable(s_stable), .fast_osc_enable(f_en), .slow_internal_enable(i_en),
        .slow_crystal_enable(x_en), .high_clock_avail(h_avail), .cpu_tick(cpu_tick),
        .periph_tick(periph_tick), .sub_tick(sub_tick), .watchdog_enable(wdt_en), .mode(mode));
    scpm_osc_model scpm_osc_model_inst (.ref_clk(ref_clk), .srst(srst), .fast_osc_enable(f_en),
        .slow_internal_enable(i_en), .slow_crystal_enable(x_en), .fast_osc_tick(f_tick),
        .slow_internal_tick(i_tick), .slow_crystal_tick(x_tick), .fast_osc_stable(f_stable),
        .slow_osc_stable(s_stable));
    // second build with the sub clock from the crystal, driven by the same stimulus
    scpm_top #(.SUB_FROM_CRYSTAL(1'b1)) scpm_top_inst_xtal (.ref_clk(ref_clk), .srst(srst),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .halt_req(halt_req), .wake_req(wake_req), .fast_osc_tick(x_f_tick),
        .slow_internal_tick(x_i_tick), .slow_crystal_tick(x_x_tick),
        .fast_osc_stable(x_f_stable), .slow_osc_stable(x_s_stable), .fast_osc_enable(x_f_en),
        .slow_internal_enable(x_i_en), .slow_crystal_enable(x_x_en), .high_clock_avail(),
        .cpu_tick(), .periph_tick(), .sub_tick(x_sub_tick), .watchdog_enable(), .mode());
    scpm_osc_model scpm_osc_model_inst_xtal (.ref_clk(ref_clk), .srst(srst),
        .fast_osc_enable(x_f_en), .slow_internal_enable(x_i_en), .slow_crystal_enable(x_x_en),
        .fast_osc_tick(x_f_tick), .slow_internal_tick(x_i_tick), .slow_crystal_tick(x_x_tick),
        .fast_osc_stable(x_f_stable), .slow_osc_stable(x_s_stable));

    // 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // compare one value and count it
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // register write: one strobe cycle, released at the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // register read: data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        chk(what, exp, reg_rdata);
    endtask

    // one-cycle halt or wake pulse, returns once the mode has settled
    task automatic pulse(input bit wake);
        @(posedge ref_clk);
        if (wake)
            wake_req <= 1'b1;
        else
            halt_req <= 1'b1;
        @(posedge ref_clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        @(negedge ref_clk);
    endtask

    // count tick outputs over a window
    task automatic watch(input int n);
        n_cpu = 0;
        n_per = 0;
        n_sub = 0;
        n_xbad = 0;
        repeat (n)
        begin
            @(negedge ref_clk);
            n_cpu += (cpu_tick === 1'b1);
            n_per += (periph_tick === 1'b1);
            n_sub += (sub_tick === 1'b1);
            n_xbad += (x_sub_tick !== x_x_tick);
        end
    endtask

    // cycles to the next cpu tick, bounded
    task automatic next_tick();
        g = 0;
        do
        begin
            @(negedge ref_clk);
            g++;
        end
        while (cpu_tick !== 1'b1 && g < 400);
    endtask

    // steady cpu tick spacing; first two gaps skipped while the divider settles
    task automatic gap(input int exp, input string what);
        repeat (3) next_tick();
        chk(what, exp[7:0], g[7:0]);
    endtask

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard: the whole sequence needs little more than a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end

    initial
    begin
        {srst, ce, reg_wr, reg_rd, halt_req, wake_req} = 6'h30;
        {reg_addr, reg_wdata} = 16'h0000;
        {miscompares, cmp_count, cycles} = '0;
        ce = 1'b1;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rd(SCPM_ADDR_CLK_MODE, 8'h03, "clk_mode reset");
        @(negedge ref_clk);
        chk("rdata after read", 8'h00, reg_rdata);
        rd(SCPM_ADDR_STATUS, 8'h01, "mode after reset");
        $display("test reset done");
        repeat (20) @(posedge ref_clk);
        rd(SCPM_ADDR_CLK_MODE, 8'h0f, "ready flags");
        wr(SCPM_ADDR_CLK_MODE, 8'hff);
        rd(SCPM_ADDR_CLK_MODE, 8'hef, "flag write ignored");
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00, "unmapped read");
        wr(SCPM_ADDR_STATUS, 8'h10);
        rd(SCPM_ADDR_STATUS, 8'h01, "status read only");
        chk("sub source pick", 8'h01, {6'h00, x_en, i_en});
        chk("crystal source pick", 8'h02, {6'h00, x_x_en, x_i_en});
        $display("test registers done");
        gap(2, "ratio one");
        for (int c = 2; c < 8; c++)
        begin
            wr(SCPM_ADDR_CLK_MODE, {c[2:0], 5'h02});
            gap(2 << (8 - c), "divided ratio");
            chk("high clock usable", 8'h03, {6'h00, f_en, h_avail});
        end
        for (int c = 0; c < 2; c++)
        begin
            wr(SCPM_ADDR_CLK_MODE, {c[2:0], 5'h02});
            gap(16, "sub clock gap");
            rd(SCPM_ADDR_STATUS, 8'h02, "slow mode");
            chk("high clock stopped", 8'h00, {6'h00, f_en, h_avail});
        end
        $display("test clock select done");
        wr(SCPM_ADDR_CTRL, 8'h02);
        wr(SCPM_ADDR_CLK_MODE, 8'h20);
        @(negedge ref_clk);
        chk("watchdog running", 8'h01, {7'h00, wdt_en});
        pulse(1'b0);
        chk("sleep mode", {3'h0, SCPM_SLEEP}, {3'h0, mode});
        chk("watchdog in sleep", 8'h00, {7'h00, wdt_en});
        pulse(1'b0);
        watch(40);
        chk("ticks in sleep", 8'h00, 8'(n_cpu + n_per + n_sub));
        chk("slow osc in sleep", 8'h00, {6'h00, x_en, i_en});
        pulse(1'b1);
        chk("wake to slow", {3'h0, SCPM_SLOW}, {3'h0, mode});
        $display("test sleep done");
        wr(SCPM_ADDR_CTRL, 8'h00);
        wr(SCPM_ADDR_CLK_MODE, 8'he3);
        repeat (10) @(posedge ref_clk);
        pulse(1'b1);
        chk("wake while running", {3'h0, SCPM_NORMAL}, {3'h0, mode});
        pulse(1'b0);
        chk("idle off mode", {3'h0, SCPM_IDLE_OFF}, {3'h0, mode});
        watch(40);
        chk("idle off ticks", 8'h01, {5'h00, n_cpu > 0, n_per > 0, n_sub > 0});
        chk("crystal sub ticks", 8'h00, 8'(n_xbad));
        chk("idle off fast osc", 8'h00, {7'h00, f_en});
        pulse(1'b1);
        wr(SCPM_ADDR_CTRL, 8'h01);
        repeat (10) @(posedge ref_clk);
        pulse(1'b0);
        chk("idle on mode", {3'h0, SCPM_IDLE_ON}, {3'h0, mode});
        watch(40);
        chk("idle on ticks", 8'h03, {5'h00, n_cpu > 0, n_per > 0, n_sub > 0});
        chk("idle on fast osc", 8'h01, {7'h00, f_en});
        pulse(1'b1);
        chk("wake to normal", {3'h0, SCPM_NORMAL}, {3'h0, mode});
        $display("test idle done");
        results();
    end
endmodule
